// ==== rtl/fso_loader.sv ====
/*
 * Flash security option loader: loads the working protection and option
 * bytes from the nonvolatile image after reset, decodes security and runs
 * the backdoor key comparison.
 * Assumes the nonvolatile image is stable while rst is released and that
 * the CPU flags fetches from secure memory and debug-originated accesses.
 */
// Summary of operation
// - Reset loads stored protect and option bytes
// - Eight-byte backdoor key held in nonvolatile area
// - Key unlock only while key enable reads 1
// - Key compare only from secure code, never debug
// - Key enable 0 disables key entirely
// - Security code 1:0 unsecured, others secured
`timescale 1ns/1ps
module fso_loader
	import fso_pkg::*;
(
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// Register port
	input  wire fso_pkg::fso_bus_req_t bus_req,
	output logic [7:0]         rdata,
	// Access origin
	input  wire logic          exec_secure,
	input  wire logic          debug_access,
	// Nonvolatile image
	input  wire fso_pkg::fso_nv_image_t nv_image,
	// Status outputs
	output logic               secured,
	output logic [7:0]         protect_out,
	output logic               load_done
);
	import fso_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	typedef enum logic [1:0] {FSO_LOAD, FSO_RUN} fso_state_t;

	fso_state_t  state_q, state_d;
	logic [7:0]  opt_q, opt_d;
	logic [7:0]  prot_q, prot_d;
	logic [7:0]  cfg_q, cfg_d;
	logic [3:0]  key_cnt_q, key_cnt_d;
	logic        key_ok_q, key_ok_d;
	logic        unlock_q, unlock_d;
	logic        fail_q, fail_d;
	logic [7:0]  rdata_q, rdata_d;
	logic [7:0]  key_byte;
	logic        key_wr;
	logic        code_secure;

	assign code_secure = (opt_q[1:0] != FSO_SEC_UNSECURED);
	assign key_byte    = nv_image.key[63 - 8 * key_cnt_q[2:0] -: 8];
	// Debug writes never reach the comparator
	assign key_wr = bus_req.wr && (bus_req.addr == FSO_ADDR_KEY_ENTRY) && exec_secure
		&& !debug_access && cfg_q[FSO_CFG_KEY_WRITE_SELECT]
		&& opt_q[FSO_OPT_KEY_UNLOCK_ENABLE];

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		state_d   = state_q;
		opt_d     = opt_q;
		prot_d    = prot_q;
		cfg_d     = cfg_q;
		key_cnt_d = key_cnt_q;
		key_ok_d  = key_ok_q;
		unlock_d  = unlock_q;
		fail_d    = fail_q;
		unique case (state_q)
			FSO_LOAD:
			begin
				// Working copies come from flash; software writes can only clear protect bits
				opt_d   = nv_image.opt & FSO_OPT_MASK;
				prot_d  = nv_image.prot;
				state_d = FSO_RUN;
			end
			FSO_RUN:
			begin
				if (bus_req.wr && bus_req.addr == FSO_ADDR_FLASH_CONFIG)
				begin
					cfg_d     = bus_req.wdata & FSO_CFG_MASK;
					key_cnt_d = 4'h0;
					key_ok_d  = 1'b1;
				end
				// Protection may only be tightened once loaded
				if (bus_req.wr && bus_req.addr == FSO_ADDR_PROTECT_WORK)
					prot_d = prot_q & bus_req.wdata;
				if (key_wr && key_cnt_q < FSO_KEY_BYTES)
				begin
					key_cnt_d = key_cnt_q + 4'h1;
					if (bus_req.wdata != key_byte)
						key_ok_d = 1'b0;
					if (key_cnt_q == FSO_KEY_BYTES - 4'h1)
					begin
						if (key_ok_q && bus_req.wdata == key_byte)
							unlock_d = 1'b1;
						else
							fail_d = 1'b1;
					end
				end
			end
			default: state_d = FSO_LOAD;
		endcase
		rdata_d = 8'h00;
		if (bus_req.rd)
		begin
			unique case (bus_req.addr)
				FSO_ADDR_OPTION_WORKING: rdata_d = opt_q;
				FSO_ADDR_FLASH_CONFIG:   rdata_d = cfg_q;
				FSO_ADDR_PROTECT_WORK:   rdata_d = prot_q;
				FSO_ADDR_STORED_PROTECT: rdata_d = nv_image.prot;
				FSO_ADDR_STORED_OPTION:  rdata_d = nv_image.opt;
				FSO_ADDR_SEC_STATUS:     rdata_d = {4'h0, fail_q, unlock_q, code_secure, secured};
				default:                 rdata_d = 8'h00;
			endcase
		end
	end

	// Unlock is volatile; only a reset clears it
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q   <= FSO_LOAD;
			opt_q     <= FSO_OPT_RESET;
			prot_q    <= FSO_PROT_RESET;
			cfg_q     <= FSO_CFG_RESET;
			key_cnt_q <= 4'h0;
			key_ok_q  <= 1'b1;
			unlock_q  <= 1'b0;
			fail_q    <= 1'b0;
			rdata_q   <= 8'h00;
		end
		else
		begin
			state_q   <= state_d;
			opt_q     <= opt_d;
			prot_q    <= prot_d;
			cfg_q     <= cfg_d;
			key_cnt_q <= key_cnt_d;
			key_ok_q  <= key_ok_d;
			unlock_q  <= unlock_d;
			fail_q    <= fail_d;
			rdata_q   <= rdata_d;
		end
	end

	assign secured     = code_secure && !unlock_q;
	assign protect_out = prot_q;
	assign load_done   = (state_q == FSO_RUN);
	assign rdata       = rdata_q;

	// ************************************************************
	// Checks
	// ************************************************************
	// Sampled rst keeps the release edge, still in reset, out of the antecedent
	chk_load_copies: assert property (@(posedge clk) disable iff (rst)
		!rst && state_q == FSO_LOAD |=> opt_q == ($past(nv_image.opt) & FSO_OPT_MASK) && prot_q == $past(nv_image.prot))
		else $error("working bytes not loaded");
	chk_unlock_needs_en: assert property (@(posedge clk) disable iff (rst)
		$rose(unlock_q) |-> opt_q[FSO_OPT_KEY_UNLOCK_ENABLE])
		else $error("unlock without key enable");
	chk_debug_blocked: assert property (@(posedge clk) disable iff (rst)
		(debug_access || !exec_secure) |=> key_cnt_q == $past(key_cnt_q)
		|| $past(bus_req.wr && bus_req.addr == FSO_ADDR_FLASH_CONFIG))
		else $error("debug access advanced key");
	chk_key_disabled: assert property (@(posedge clk) disable iff (rst)
		!opt_q[FSO_OPT_KEY_UNLOCK_ENABLE] |-> !unlock_q)
		else $error("unlocked while key disabled");
	chk_sec_code: assert property (@(posedge clk) disable iff (rst)
		load_done && opt_q[1:0] == FSO_SEC_UNSECURED |-> !secured)
		else $error("unsecured code reads secured");
	chk_unlock_sticky: assert property (@(posedge clk) disable iff (rst)
		unlock_q |=> unlock_q)
		else $error("unlock dropped before reset");
	chk_unlock_count: assert property (@(posedge clk) disable iff (rst)
		$rose(unlock_q) |-> $past(key_cnt_q) == 4'h7 && key_cnt_q == 4'h8)
		else $error("unlock not after eighth byte");
	chk_fail_no_unlock: assert property (@(posedge clk) disable iff (rst)
		$rose(fail_q) |-> !unlock_q)
		else $error("failed compare unlocked");
	cov_unlock: cover property (@(posedge clk) disable iff (rst) $rose(unlock_q));
	cov_fail: cover property (@(posedge clk) disable iff (rst) $rose(fail_q));
	cov_unsecured: cover property (@(posedge clk) disable iff (rst) load_done && !secured);

endmodule // fso_loader

// ==== rtl/fso_pkg.sv ====
/*
 * Package for the flash security option loader: register addresses, field
 * positions, reset values and shared carrier types.
 * Assumes a byte-wide CPU register port with 16-bit addresses.
 */
package fso_pkg;

	// ************************************************************
	// Register addresses
	// ************************************************************
	localparam logic [15:0] FSO_ADDR_OPTION_WORKING = 16'h1821;
	localparam logic [15:0] FSO_ADDR_FLASH_CONFIG   = 16'h1823;
	localparam logic [15:0] FSO_ADDR_PROTECT_WORK   = 16'h1824;
	localparam logic [15:0] FSO_ADDR_KEY_STORE_LO   = 16'hffb0;
	localparam logic [15:0] FSO_ADDR_KEY_STORE_HI   = 16'hffb7;
	localparam logic [15:0] FSO_ADDR_STORED_PROTECT = 16'hffbd;
	localparam logic [15:0] FSO_ADDR_STORED_OPTION  = 16'hffbf;
	// Key entry and status registers
	localparam logic [15:0] FSO_ADDR_KEY_ENTRY      = 16'h1828;
	localparam logic [15:0] FSO_ADDR_SEC_STATUS     = 16'h1829;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int FSO_OPT_KEY_UNLOCK_ENABLE     = 7;
	localparam int FSO_OPT_VECTOR_REDIRECT_DIS   = 6;
	localparam int FSO_OPT_SECURITY_CODE_HIGH    = 1;
	localparam int FSO_OPT_SECURITY_CODE_LOW     = 0;
	localparam int FSO_CFG_KEY_WRITE_SELECT      = 5;
	localparam int FSO_PROT_DISABLE              = 0;

	// Option bits that are stored; others read 0
	localparam logic [7:0] FSO_OPT_MASK          = 8'hc3;
	localparam logic [7:0] FSO_CFG_MASK          = 8'h20;
	localparam logic [1:0] FSO_SEC_UNSECURED     = 2'h2;
	// Secure until the load has completed
	localparam logic [7:0] FSO_OPT_RESET         = 8'h00;
	localparam logic [7:0] FSO_PROT_RESET        = 8'hff;
	localparam logic [7:0] FSO_CFG_RESET         = 8'h00;
	localparam logic [3:0] FSO_KEY_BYTES         = 4'h8;

	// ************************************************************
	// Types
	// ************************************************************
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} fso_bus_req_t;

	typedef struct packed {
		logic [63:0] key;
		logic [7:0]  prot;
		logic [7:0]  opt;
	} fso_nv_image_t;

endpackage

// ==== sim/test_fso_loader.sv ====
/*
 * Self-checking bench for the flash security option loader.
 * Assumes only the loader's own ports; the bench plays CPU, access origin and flash image.
 */
`timescale 1ns/1ps
module test_fso_loader;
	import fso_pkg::*;
	localparam logic [63:0] KEY = 64'h0123456789abcdef;
	logic          clk          = 1'b0;
	logic          rst          = 1'b1;
	fso_bus_req_t  bus_req      = '0;
	logic [7:0]    rdata;
	logic          exec_secure  = 1'b0;
	logic          debug_access = 1'b0;
	fso_nv_image_t nv_image     = '{KEY, 8'h5a, 8'h83};
	logic          secured;
	logic [7:0]    protect_out;
	logic          load_done;
	int            fails        = 0;
	int            n_tests      = 0;
	int            cycles       = 0;

	fso_loader fso_loader_i (.clk(clk), .rst(rst), .bus_req(bus_req), .rdata(rdata), .exec_secure(exec_secure),
		.debug_access(debug_access), .nv_image(nv_image), .secured(secured), .protect_out(protect_out),
		.load_done(load_done));

	always #12.5 clk = ~clk;

	// Hang guard: the whole run needs well under 2000 cycles
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 6000)
		begin
			fails = fails + 1;
			conclude();
		end
	end

	// ************************************************************
	// Bus and check tasks
	// ************************************************************
	task automatic conclude;
		if (fails == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{a, d, 1'b1, 1'b0};
	endtask

	task automatic idle;
		@(posedge clk);
		bus_req <= '0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string name);
		@(posedge clk);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus_req <= '0;
		#1;
		chk(name, exp, rdata);
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic do_reset(input logic [7:0] p, input logic [7:0] o, input logic s);
		@(posedge clk);
		rst      <= 1'b1;
		nv_image <= '{KEY, p, o};
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("load_done", 8'h00, {7'h00, load_done});
		repeat (2) @(posedge clk);
		#1;
		chk("load_done", 8'h01, {7'h00, load_done});
		chk("protect_out", p, protect_out);
		chk("secured", {7'h00, s}, {7'h00, secured});
		rd(FSO_ADDR_OPTION_WORKING, o & FSO_OPT_MASK, "option_working");
	endtask

	task automatic enter_key(input logic [63:0] k, input logic sec, input logic dbg, input logic [7:0] st);
		@(posedge clk);
		exec_secure  <= sec;
		debug_access <= dbg;
		wr(FSO_ADDR_FLASH_CONFIG, 8'h20);
		for (int i = 0; i < 8; i++)
			wr(FSO_ADDR_KEY_ENTRY, k[63-8*i -: 8]);
		idle();
		rd(FSO_ADDR_SEC_STATUS, st, "status");
		chk("secured", {7'h00, st[0]}, {7'h00, secured});
	endtask

	task automatic reg_access;
		wr(FSO_ADDR_PROTECT_WORK, 8'h0f);
		idle();
		rd(FSO_ADDR_PROTECT_WORK, 8'h0a, "protect_working");
		chk("protect_out", 8'h0a, protect_out);
		wr(FSO_ADDR_OPTION_WORKING, 8'h00);
		rd(FSO_ADDR_OPTION_WORKING, 8'h83, "option_working");
		rd(16'h1822, 8'h00, "unmapped");
		rd(FSO_ADDR_KEY_STORE_LO, 8'h00, "key_store");
		rd(FSO_ADDR_STORED_PROTECT, 8'h5a, "stored_protect_byte");
		rd(FSO_ADDR_STORED_OPTION, 8'h83, "stored_option_byte");
	endtask

	initial
	begin
		do_reset(8'h5a, 8'h83, 1'b1);
		reg_access();
		enter_key(KEY, 1'b1, 1'b1, 8'h03);
		enter_key(KEY, 1'b0, 1'b0, 8'h03);
		enter_key(KEY ^ 64'h1, 1'b1, 1'b0, 8'h0b);
		enter_key(KEY, 1'b1, 1'b0, 8'h0e);
		do_reset(8'h5a, 8'h83, 1'b1);
		do_reset(8'h5a, 8'h03, 1'b1);
		enter_key(KEY, 1'b1, 1'b0, 8'h03);
		for (int c = 0; c < 4; c++)
			do_reset(8'hff, 8'h80 | 8'(c), c != 2);
		conclude();
	end
endmodule // test_fso_loader
